// >>> rtl/sdc_core.sv
/*
 * Command core of a two-bank synchronous DRAM: pin sampling, command decode,
 * per-bank state, mode latch, burst column generator, read latency pipe and
 * a write stream into a FIFO toward the storage array.
 * Assumes the storage array answers rd_req in the same cycle on rd_data and
 * drains wr_word when it raises wr_ready; the controller keeps its timing.
 */
`timescale 1ns/100ps
module sdc_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire sdc_pkg::sdc_pins_s pins,
    output logic [sdc_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic rd_req,
    output sdc_pkg::sdc_loc_s rd_loc,
    input wire logic [sdc_pkg::DATA_W-1:0] rd_data,
    output logic wr_valid,
    input wire logic wr_ready,
    output sdc_pkg::sdc_word_s wr_word,
    output sdc_pkg::sdc_bank_e bank0_state,
    output sdc_pkg::sdc_bank_e bank1_state,
    output sdc_pkg::sdc_mode_s mode,
    output logic power_down,
    output logic self_refresh,
    output logic suspended,
    output logic cmd_illegal
);
    import sdc_pkg::*;

    sdc_pins_s pin_m;
    sdc_pins_s pin;
    logic cke_prev;
    logic run;
    logic cmd_v;
    logic [2:0] op;
    logic sel;
    logic ap;
    logic [COL_W-1:0] cmd_col;
    logic is_rd;
    logic is_wr;
    logic is_open;
    logic is_close;
    logic is_stop;
    logic is_ref;
    logic is_mode;
    logic new_burst;
    logic stop_ok;
    logic both_idle;
    logic sr_entry;

    sdc_bank_e bank_st [BANKS];
    logic [ROW_W-1:0] row [BANKS];

    logic bu_act;
    logic bu_wr;
    logic bu_bank;
    logic bu_bt;
    logic [COL_W-1:0] bu_start;
    logic [LEN_W-1:0] bu_idx;
    logic [LEN_W-1:0] bu_len;
    logic fin;
    logic [LEN_W-1:0] cur_len;
    logic beat_v;
    logic beat_wr;
    logic beat_bank;
    logic [COL_W-1:0] beat_col;
    logic beat_go;
    logic fifo_in_ready;
    sdc_word_s fifo_in;
    logic cl_slot;
    sdc_slot_s pipe [2];

    // pins come from another timing domain, so two flops before any use
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_m <= PINS_IDLE;
            pin <= PINS_IDLE;
        end else if (ce) begin
            pin_m <= pins;
            pin <= pin_m;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cke_prev <= 1'b0;
        end else if (ce) begin
            cke_prev <= pin.cke;
        end
    end

    // the first sampled high already runs; no extra wake cycle
    // limitation: the two sampling flops still add two clocks of delay
    assign run = ce && pin.cke;
    assign cmd_v = run && !pin.cs_n;
    assign op = {pin.ras_n, pin.cas_n, pin.we_n};
    assign sel = pin.addr[BANK_BIT];
    assign ap = pin.addr[AP_BIT];
    // A8 and A9 fall outside the column slice
    assign cmd_col = pin.addr[COL_W-1:0];

    // chip_select high is chip_ignore; otherwise the strobes pick one
    assign is_rd = cmd_v && (op == OP_READ);
    assign is_wr = cmd_v && (op == OP_WRITE);
    assign is_open = cmd_v && (op == OP_OPEN);
    assign is_close = cmd_v && (op == OP_CLOSE);
    assign is_stop = cmd_v && (op == OP_STOP);
    assign is_ref = cmd_v && (op == OP_REFRESH);
    assign is_mode = cmd_v && (op == OP_MODE);
    assign new_burst = is_rd || is_wr;

    assign both_idle = (bank_st[0] == BK_IDLE) && (bank_st[1] == BK_IDLE);

    // refresh strobes seen on the cycle clock_enable falls
    assign sr_entry = ce && cke_prev && !pin.cke && !pin.cs_n && (op == OP_REFRESH);

    function automatic logic [LEN_W-1:0] burst_len(input logic [2:0] bl);
        logic [LEN_W-1:0] len;
        len = LEN_1;
        case (bl)
            BL_2: len = LEN_2;
            BL_4: len = LEN_4;
            BL_8: len = LEN_8;
            BL_PAGE: len = LEN_PAGE;
            default: len = LEN_1;
        endcase
        return len;
    endfunction

    // column of beat idx inside the aligned block of the burst length
    function automatic logic [COL_W-1:0] col_at(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] idx,
        input logic [LEN_W-1:0] len,
        input logic bt
    );
        logic [COL_W-1:0] wrap;
        logic [COL_W-1:0] off;
        wrap = COL_W'(len - LEN_1);
        if (bt == BT_SEQ) begin
            off = (start + idx) & wrap;
        end else begin
            off = (start ^ idx) & wrap;
        end
        return (start & ~wrap) | off;
    endfunction

    // single-write mode forces one word per write only
    // length field picks 1, 2, 4, 8 or page
    always_comb begin
        if (is_wr && (mode.wmode == WM_SINGLE)) begin
            cur_len = LEN_1;
        end else begin
            cur_len = burst_len(mode.bl);
        end
    end

    assign fin = bu_act && (bu_idx == bu_len);

    // the command cycle is the first beat at the supplied column
    assign beat_v = new_burst || (bu_act && !fin);
    assign beat_wr = new_burst ? is_wr : bu_wr;
    assign beat_bank = new_burst ? sel : bu_bank;
    // later columns made internally in the programmed order
    assign beat_col = new_burst ? cmd_col
        : col_at(bu_start, bu_idx[COL_W-1:0], bu_len, bu_bt);

    // a full write FIFO holds the burst rather than drop a word
    assign beat_go = run && beat_v && !(beat_wr && !fifo_in_ready);

    // burst_stop honoured only with page length
    assign stop_ok = is_stop && (mode.bl == BL_PAGE) && bu_act;

    always_ff @(posedge clk) begin
        if (rst) begin
            bu_act <= 1'b0;
            bu_wr <= 1'b0;
            bu_bank <= 1'b0;
            bu_bt <= BT_SEQ;
            bu_start <= '0;
            bu_idx <= '0;
            bu_len <= LEN_1;
        end else if (run) begin
            if (new_burst) begin
                bu_act <= 1'b1;
                bu_wr <= is_wr;
                bu_bank <= sel;
                bu_bt <= mode.bt;
                bu_start <= cmd_col;
                bu_len <= cur_len;
                bu_idx <= beat_go ? LEN_1 : '0;
            end else if (stop_ok || fin || (is_close && (ap || (sel == bu_bank)))) begin
                bu_act <= 1'b0;
            end else if (beat_go) begin
                // page bursts run 256 beats, wrapping the column
                bu_idx <= bu_idx + LEN_1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bank_st[0] <= BK_IDLE;
            bank_st[1] <= BK_IDLE;
        end else if (run) begin
            for (int b = 0; b < BANKS; b++) begin
                // each bank reacts to commands that address it, to a close with A10 high and to a new burst on the other bank
                if (is_close && (ap || (sel == 1'(b)))) begin
                    bank_st[b] <= BK_IDLE;
                end else if (is_open && (sel == 1'(b)) && (bank_st[b] == BK_IDLE)) begin
                    bank_st[b] <= BK_ACTIVE;
                end else if (is_rd && (sel == 1'(b))) begin
                    bank_st[b] <= ap ? BK_READ_CLOSE : BK_READ;
                end else if (is_wr && (sel == 1'(b))) begin
                    bank_st[b] <= ap ? BK_WRITE_CLOSE : BK_WRITE;
                end else if (bu_act && (bu_bank == 1'(b)) && (new_burst || stop_ok || fin)) begin
                    // burst ended or taken over by the other bank
                    if ((bank_st[b] == BK_READ_CLOSE) || (bank_st[b] == BK_WRITE_CLOSE)) begin
                        bank_st[b] <= BK_IDLE;
                    end else begin
                        bank_st[b] <= BK_ACTIVE;
                    end
                end
            end
        end
    end

    assign bank0_state = bank_st[0];
    assign bank1_state = bank_st[1];

    always_ff @(posedge clk) begin
        if (rst) begin
            row[0] <= '0;
            row[1] <= '0;
        end else if (is_open && (bank_st[sel] == BK_IDLE)) begin
            // a refused open must not disturb the row of an active bank
            row[sel] <= pin.addr[ROW_W-1:0];
        end
    end

    // controller guarantees both banks idle here
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= MODE_RESET;
        end else if (is_mode) begin
            mode <= sdc_mode_s'(pin.addr);
        end
    end

    // write beats carry the word sampled on the beat cycle
    assign fifo_in.loc.bank = beat_bank;
    assign fifo_in.loc.row = row[beat_bank];
    assign fifo_in.loc.col = beat_col;
    assign fifo_in.mask = pin.dqm;
    assign fifo_in.data = pin.dq;

    sdc_fifo #(
        .W($bits(sdc_word_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(beat_go && beat_wr),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_word)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_req <= 1'b0;
            rd_loc <= '0;
        end else if (ce) begin
            rd_req <= beat_go && !beat_wr;
            if (beat_go && !beat_wr) begin
                rd_loc.bank <= beat_bank;
                rd_loc.row <= row[beat_bank];
                rd_loc.col <= beat_col;
            end
        end
    end

    // latency 3 enters one slot further back than latency 2
    assign cl_slot = mode.cl == CL_3;

    always_ff @(posedge clk) begin
        if (rst) begin
            pipe[0] <= SLOT_IDLE;
            pipe[1] <= SLOT_IDLE;
        end else if (ce) begin
            pipe[0] <= pipe[1];
            pipe[1] <= SLOT_IDLE;
            if (rd_req) begin
                pipe[cl_slot] <= '{oe_n: 1'b0, data: rd_data};
            end
        end
    end

    assign dq_out = pipe[0].data;
    assign dq_oe_n = pipe[0].oe_n;

    // low power needs idle banks, else clock_enable low is a suspend
    always_ff @(posedge clk) begin
        if (rst) begin
            power_down <= 1'b0;
            suspended <= 1'b0;
            self_refresh <= 1'b0;
        end else if (ce) begin
            power_down <= !pin.cke && both_idle && !bu_act && !self_refresh && !sr_entry;
            suspended <= !pin.cke && !(both_idle && !bu_act);
            if (pin.cke) begin
                self_refresh <= 1'b0;
            end else if (sr_entry && both_idle) begin
                self_refresh <= 1'b1;
            end
        end
    end

    // one-cycle flag for commands outside the protocol
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_illegal <= 1'b0;
        end else if (ce) begin
            cmd_illegal <= (is_stop && (mode.bl != BL_PAGE))
                || (is_open && (bank_st[sel] != BK_IDLE))
                || (new_burst && (bank_st[sel] == BK_IDLE))
                || (is_mode && !both_idle)
                || (is_ref && !both_idle);
        end
    end
endmodule

// >>> rtl/sdc_pkg.sv
/*
 * Shared constants, command codes, mode fields and carrier types for the
 * two-bank synchronous DRAM command core and its write-data FIFO.
 * Assumes a single 40 MHz clock and a controller that keeps its own side
 * of the command protocol.
 */
package sdc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int MASK_W = 2;
    localparam int COL_W = 8;
    localparam int ROW_W = 11;
    localparam int LEN_W = 9;
    localparam int BANKS = 2;
    localparam int BANK_BIT = 11;
    localparam int AP_BIT = 10;
    localparam int FIFO_DEPTH = 16;

    // command codes as {ras_n, cas_n, we_n} with chip_select low
    localparam logic [2:0] OP_NOP = 3'h7;
    localparam logic [2:0] OP_STOP = 3'h6;
    localparam logic [2:0] OP_READ = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_OPEN = 3'h3;
    localparam logic [2:0] OP_CLOSE = 3'h2;
    localparam logic [2:0] OP_REFRESH = 3'h1;
    localparam logic [2:0] OP_MODE = 3'h0;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam logic BT_SEQ = 1'h0;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_3 = 3'h3;
    localparam logic [4:0] WM_BURST = 5'h00;
    localparam logic [4:0] WM_SINGLE = 5'h04;

    localparam logic [LEN_W-1:0] LEN_1 = 9'h001;
    localparam logic [LEN_W-1:0] LEN_2 = 9'h002;
    localparam logic [LEN_W-1:0] LEN_4 = 9'h004;
    localparam logic [LEN_W-1:0] LEN_8 = 9'h008;
    localparam logic [LEN_W-1:0] LEN_PAGE = 9'h100;

    typedef enum logic [2:0] {
        BK_IDLE,
        BK_ACTIVE,
        BK_READ,
        BK_WRITE,
        BK_READ_CLOSE,
        BK_WRITE_CLOSE
    } sdc_bank_e;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] dqm;
        logic [DATA_W-1:0] dq;
    } sdc_pins_s;

    // field order matches A11..A0 so a mode_load is a plain cast
    typedef struct packed {
        logic [4:0] wmode;
        logic [2:0] cl;
        logic bt;
        logic [2:0] bl;
    } sdc_mode_s;

    typedef struct packed {
        logic bank;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
    } sdc_loc_s;

    typedef struct packed {
        sdc_loc_s loc;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] data;
    } sdc_word_s;

    typedef struct packed {
        logic oe_n;
        logic [DATA_W-1:0] data;
    } sdc_slot_s;

    localparam sdc_pins_s PINS_IDLE = '{cke: 1'h0, cs_n: 1'h1, ras_n: 1'h1,
        cas_n: 1'h1, we_n: 1'h1, addr: 12'h000, dqm: 2'h3, dq: 16'h0000};
    localparam sdc_mode_s MODE_RESET = '{wmode: WM_BURST, cl: CL_2, bt: BT_SEQ,
        bl: BL_1};
    localparam sdc_slot_s SLOT_IDLE = '{oe_n: 1'h1, data: 16'h0000};
endpackage

// >>> rtl/sdc_fifo.sv
/*
 * Parameterised first-in first-out buffer with a registered output stage.
 * Assumes one clock; ce low freezes all state.
 */
`timescale 1ns/100ps
module sdc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic empty;
    logic push;
    logic load;

    assign empty = wr_ptr == rd_ptr;
    assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign push = in_valid && in_ready;
    // output stage refills as soon as it is empty or being taken
    assign load = !empty && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (ce) begin
            if (load) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_ptr[AW-1:0]];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// >>> tb/sdc_core_sva.sv
/*
 * concurrent checks on the command core ports.
 * assumes it is bound to sdc_core and sees the same single clock.
 */
`timescale 1ns/100ps
module sdc_core_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire sdc_pkg::sdc_pins_s pins,
    input wire logic dq_oe_n,
    input wire logic rd_req,
    input wire sdc_pkg::sdc_loc_s rd_loc,
    input wire sdc_pkg::sdc_bank_e bank0_state,
    input wire sdc_pkg::sdc_bank_e bank1_state,
    input wire sdc_pkg::sdc_mode_s mode,
    input wire logic power_down,
    input wire logic cmd_illegal
);
    import sdc_pkg::*;
    sdc_pins_s p1;
    sdc_pins_s p2;
    logic act;
    logic [2:0] op;
    // own copy of the two sync stages, so commands line up with the core
    always_ff @(posedge clk) begin
        if (rst) begin
            p1 <= PINS_IDLE;
            p2 <= PINS_IDLE;
        end else if (ce) begin
            p1 <= pins;
            p2 <= p1;
        end
    end
    assign act = ce && p2.cke && !p2.cs_n;
    assign op = {p2.ras_n, p2.cas_n, p2.we_n};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_mode_latch: assert property (
        act && op == OP_MODE |=> mode == sdc_mode_s'($past(p2.addr)))
        else $error("mode word not latched");
    a_open_idle: assert property (
        act && op == OP_OPEN && (p2.addr[11] ? bank1_state : bank0_state) == BK_IDLE
        |=> ($past(p2.addr[11]) ? bank1_state : bank0_state) == BK_ACTIVE)
        else $error("open did not activate bank");
    a_open_busy: assert property (
        act && op == OP_OPEN && !p2.addr[11] && bank0_state != BK_IDLE |=> cmd_illegal)
        else $error("open of busy bank not flagged");
    a_close_both: assert property (
        act && op == OP_CLOSE && p2.addr[10]
        |=> bank0_state == BK_IDLE && bank1_state == BK_IDLE)
        else $error("close both left a bank open");
    a_close_one: assert property (
        act && op == OP_CLOSE && p2.addr[11:10] == 2'h0 && bank1_state == BK_ACTIVE
        |=> bank0_state == BK_IDLE && bank1_state == BK_ACTIVE)
        else $error("single close touched wrong bank");
    a_read_state: assert property (
        act && op == OP_READ && mode.bl != BL_1
        |=> ($past(p2.addr[11]) ? bank1_state : bank0_state)
        == ($past(p2.addr[10]) ? BK_READ_CLOSE : BK_READ))
        else $error("read state wrong");
    a_write_state: assert property (
        act && op == OP_WRITE && mode.bl != BL_1 && mode.wmode == WM_BURST
        |=> ($past(p2.addr[11]) ? bank1_state : bank0_state)
        == ($past(p2.addr[10]) ? BK_WRITE_CLOSE : BK_WRITE))
        else $error("write state wrong");
    a_read_beat: assert property (
        act && op == OP_READ |=> rd_req && rd_loc.bank == $past(p2.addr[11])
        && rd_loc.col == $past(p2.addr[7:0]))
        else $error("first read beat address wrong");
    a_lat_two: assert property (
        act && op == OP_READ && mode.cl != CL_3 |-> ##2 !dq_oe_n)
        else $error("latency two missed");
    a_lat_three: assert property (
        act && op == OP_READ && mode.cl == CL_3 |-> ##3 !dq_oe_n)
        else $error("latency three missed");
    a_stop_bad: assert property (
        act && op == OP_STOP && mode.bl != BL_PAGE |=> cmd_illegal)
        else $error("stop without page length not flagged");
    a_wake_up: assert property (
        ce && p2.cke && power_down |=> !power_down)
        else $error("power down not left");
endmodule

// >>> tb/sdc_store_model.sv
/*
 * storage array stand-in: answers reads at once, drains writes with stalls.
 * assumes rd_loc is steady while rd_req is high.
 */
`timescale 1ns/100ps
module sdc_store_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic rd_req,
    input wire sdc_pkg::sdc_loc_s rd_loc,
    output logic [sdc_pkg::DATA_W-1:0] rd_data,
    output logic wr_ready
);
    import sdc_pkg::*;
    logic [DATA_W-1:0] last;
    // word built from its address so every beat is predictable
    // no held value between requests, so a late sample shows up
    assign rd_data = rd_req ? {rd_loc.bank, rd_loc.row[6:0], rd_loc.col} : ~last;
    always_ff @(posedge clk) begin
        if (rst) begin
            last <= 16'h0000;
            wr_ready <= 1'h0;
        end else begin
            if (rd_req) begin
                last <= rd_data;
            end
            wr_ready <= !stall;
        end
    end
endmodule

// >>> tb/tb.sv
/*
 * self-checking bench for the command core with a storage array model.
 * assumes the core, its fifo and the package are compiled first.
 */
`timescale 1ns/100ps
module tb;
    import sdc_pkg::*;
    logic clk, rst, ce, stall, hold;
    sdc_pins_s p;
    logic [DATA_W-1:0] dq_out, rd_data;
    logic dq_oe_n, rd_req, wr_valid, wr_ready, power_down, self_refresh, suspended, cmd_illegal;
    sdc_loc_s rd_loc;
    sdc_word_s wr_word;
    sdc_bank_e bank0_state, bank1_state;
    sdc_mode_s mode;
    sdc_word_s exp_q[$];
    logic [ROW_W-1:0] row_of [2];
    sdc_mode_s mset;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    sdc_core u_dut (.clk(clk), .rst(rst), .ce(ce), .pins(p), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .rd_req(rd_req), .rd_loc(rd_loc), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
        .bank0_state(bank0_state), .bank1_state(bank1_state), .mode(mode),
        .power_down(power_down), .self_refresh(self_refresh), .suspended(suspended),
        .cmd_illegal(cmd_illegal));
    sdc_store_model u_store (.clk(clk), .rst(rst), .stall(stall), .rd_req(rd_req),
        .rd_loc(rd_loc), .rd_data(rd_data), .wr_ready(wr_ready));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        stall <= hold | ($urandom % 4 == 0);
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // transfer happens at the next rising edge; look while it is settled
    always @(negedge clk) begin
        if (!rst && wr_valid === 1'b1 && wr_ready === 1'b1) begin
            cmp(exp_q.size() > 0, 1);
            if (exp_q.size() > 0) cmp(wr_word, exp_q.pop_front());
        end
    end

    function automatic logic [7:0] colf(logic [7:0] s, int i, int l, logic bt);
        logic [7:0] m;
        m = 8'(l - 1);
        return bt ? (s & ~m) | ((s ^ 8'(i)) & m) : (s & ~m) | ((s + 8'(i)) & m);
    endfunction
    function automatic sdc_bank_e st(input logic b);
        return b ? bank1_state : bank0_state;
    endfunction
    function automatic int blen(input logic [2:0] c);
        return c == BL_PAGE ? 256 : 1 << c;
    endfunction

    task automatic drv(input logic [2:0] op, input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        p.cs_n <= 1'h0;
        {p.ras_n, p.cas_n, p.we_n} <= op;
        p.addr <= a;
        p.dq <= d;
        p.dqm <= d[1:0];
    endtask
    task automatic beat(input logic [15:0] d);
        drv(OP_NOP, p.addr, d);
    endtask
    // released data lines show the inverse, never a held word
    task automatic idle(input int n);
        repeat (n) beat(~p.dq);
        #1;
    endtask
    task automatic see_illegal();
        int n;
        idle(1);
        n = 0;
        while (cmd_illegal !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(cmd_illegal, 1);
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        #1;
        cmp(exp_q.size(), 0);
    endtask

    task automatic setup(input logic [11:0] m);
        drv(OP_CLOSE, 12'h400, 16'h0000);
        idle(2);
        drv(OP_MODE, m, 16'h0000);
        idle(4);
        mset = sdc_mode_s'(m);
        cmp(mode, m);
        for (int b = 0; b < 2; b++) begin
            row_of[b] = 11'($urandom);
            drv(OP_OPEN, {b[0], row_of[b]}, 16'h0000);
            idle(4);
            cmp(st(b[0]), BK_ACTIVE);
        end
    endtask

    task automatic rd(input logic b, input logic [7:0] c, input logic ap, input int cnt);
        int n, l;
        l = blen(mset.bl);
        drv(OP_READ, {b, ap, 2'($urandom), c}, 16'h0000);
        idle(1);
        n = 1;
        while (dq_oe_n !== 1'b0 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(n, mset.cl == CL_3 ? 5 : 4);
        for (int i = 0; i < cnt; i++) begin
            cmp(dq_out, {b, row_of[b][6:0], colf(c, i, l, mset.bt)});
            @(posedge clk);
            #1;
        end
        if (cnt == l) cmp(dq_oe_n, 1);
    endtask

    task automatic wr(input logic b, input logic [7:0] c, input logic ap, input int l,
        input logic fix);
        logic [15:0] d;
        sdc_word_s w;
        for (int i = 0; i < l; i++) begin
            d = fix ? 16'h5a5a : 16'($urandom);
            w = '{'{b, row_of[b], colf(c, i, l, mset.bt)}, d[1:0], d};
            exp_q.push_back(w);
            if (i == 0) drv(OP_WRITE, {b, ap, 2'h3, c}, d);
            else beat(d);
        end
    endtask

    initial begin
        void'($urandom(27));
        rst = 1'h1;
        ce = 1'h1;
        hold = 1'h0;
        stall = 1'h0;
        p = PINS_IDLE;
        p.cke = 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        drv(OP_CLOSE, 12'h400, 16'h0000);
        idle(2);
        repeat (2) begin
            drv(OP_REFRESH, 12'h000, 16'h0000);
            idle(2);
        end
        cmp(bank0_state, BK_IDLE);
        for (int i = 0; i < 32; i++) begin
            logic [11:0] m;
            logic b, ap;
            m = {i[4] ? WM_SINGLE : WM_BURST, i[3] ? CL_3 : CL_2, i[2], 3'(i[1:0])};
            setup(m);
            if (i == 0) begin
                drv(OP_STOP, 12'h000, 16'h0000);
                see_illegal();
            end
            b = 1'($urandom);
            ap = 1'($urandom);
            rd(b, 8'($urandom), ap, blen(m[2:0]));
            idle(8);
            cmp(st(b), ap ? BK_IDLE : BK_ACTIVE);
            cmp(st(!b), BK_ACTIVE);
            ap = 1'($urandom);
            wr(!b, 8'($urandom), ap, i[4] ? 1 : blen(m[2:0]), 1'h0);
            idle(1);
            drain();
            cmp(st(!b), ap ? BK_IDLE : BK_ACTIVE);
        end
        setup({WM_BURST, CL_2, BT_SEQ, BL_PAGE});
        drv(OP_OPEN, 12'h000, 16'h0000);
        see_illegal();
        rd(1'h0, 8'hf8, 1'h0, 20);
        drv(OP_STOP, 12'h000, 16'h0000);
        idle(8);
        cmp(dq_oe_n, 1);
        cmp(bank0_state, BK_ACTIVE);
        // fill the fifo with one constant word so a held beat cannot change data
        hold <= 1'h1;
        wr(1'h1, 8'h80, 1'h0, 256, 1'h1);
        repeat (20) beat(16'h5a5a);
        #1;
        cmp(wr_valid, 1);
        cmp(bank1_state, BK_WRITE);
        p.cke <= 1'h0;
        repeat (4) beat(16'h5a5a);
        #1;
        cmp(suspended, 1);
        p.cke <= 1'h1;
        hold <= 1'h0;
        for (int n = 0; n < 3000 && bank1_state === BK_WRITE; n++) beat(16'h5a5a);
        idle(1);
        drain();
        cmp(bank1_state, BK_ACTIVE);
        drv(OP_CLOSE, 12'h000, 16'h0000);
        idle(4);
        cmp(bank0_state, BK_IDLE);
        cmp(bank1_state, BK_ACTIVE);
        drv(OP_CLOSE, 12'h400, 16'h0000);
        idle(4);
        p.cke <= 1'h0;
        idle(4);
        cmp(power_down, 1);
        p.cke <= 1'h1;
        idle(4);
        cmp(power_down, 0);
        drv(OP_REFRESH, 12'h000, 16'h0000);
        p.cke <= 1'h0;
        idle(4);
        cmp(self_refresh, 1);
        p.cke <= 1'h1;
        idle(4);
        cmp(self_refresh, 0);
        // clock enable low must swallow a command, not delay it
        ce <= 1'h0;
        drv(OP_OPEN, 12'h800, 16'h0000);
        idle(4);
        cmp(bank1_state, BK_IDLE);
        ce <= 1'h1;
        idle(4);
        cmp(bank1_state, BK_IDLE);
        finish_test();
    end
endmodule

bind sdc_core sdc_core_sva u_sva (.clk(clk), .rst(rst), .ce(ce), .pins(pins),
    .dq_oe_n(dq_oe_n), .rd_req(rd_req), .rd_loc(rd_loc), .bank0_state(bank0_state),
    .bank1_state(bank1_state), .mode(mode), .power_down(power_down),
    .cmd_illegal(cmd_illegal));
